//--- modbus_slave_link_config.sv
// Configuration, supervision and frame qualification for the slave link.
// Assumes a frame engine on core_clk that delivers received bytes and
// frame delimiters, and serves parameter requests through the param port.

// Contract
// - Hold own station address, legal range 1 to 255, set by configuration.
// - Address match depends only on the configured address value.
// - Protocol select 0 disables fieldbus, 1 enables Modbus; default off.
// - Rate codes 0 to 8 select 300 through 57600 baud; default 5.
// - Parity 0 none two stops, 1 even one stop, 2 odd one stop.
// - Master and slaves use identical rate and parity settings.
// - Count faulty messages 0..64 and good 0..999, reported as one value.
// - Status value is read-only; writes refused, read-write parameters accepted.
// - Writing 1 to counter clear zeroes both counters; 0 does nothing.
// - Enabled with nonzero timeout, silence beyond set seconds raises error 53.
// - Command source 1 terminals, 2 panel, 3 serial bus.
// - Setpoint code 2 takes bus setpoint; active fixed frequencies override all.
// - Answer only on own address match; execute broadcasts without reply.
// - Recompute 16-bit frame check while receiving; flag error on mismatch.
// - At least 3.5 character times idle before a response.
module modbus_slave_link_config
   import modbus_link_pkg::*;
#(
   parameter int unsigned CLK_HZ = modbus_link_pkg::CLK_HZ_DEFAULT
) (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        nrst,
   // Parameter access from the frame engine
   input  wire modbus_link_pkg::param_req_t preq,
   output modbus_link_pkg::param_rsp_t      prsp,
   // Received byte stream
   input  wire logic                        rx_byte_valid,
   input  wire logic [7:0]                  rx_byte,
   input  wire logic                        frame_start,
   input  wire logic                        frame_end,
   // Drive state
   input  wire logic                        fixed_freq_active,
   // Link settings and frame qualification
   output modbus_link_pkg::link_cfg_t       link_cfg,
   output modbus_link_pkg::frame_evt_t      frame_evt,
   output logic                             turnaround_ok,
   // Supervision and source selection
   output logic                             fieldbus_error,
   output logic [7:0]                       error_code,
   output logic                             cmd_from_terminals,
   output logic                             cmd_from_panel,
   output logic                             cmd_from_bus,
   output logic                             setpoint_from_bus,
   output logic [2:0]                       active_setpoint_src
);
   import modbus_link_pkg::*;

   logic [15:0] setpoint_q, command_q, protocol_q, station_q;
   logic [15:0] rate_q, parity_q, timeout_q, clear_q;
   logic [6:0]  bad_q;
   logic [9:0]  good_q;
   logic [15:0] crc_q;
   logic [7:0]  nbytes_q, faddr_q;
   logic [31:0] idle_cnt_q, sec_pre_q;
   logic [7:0]  sec_cnt_q;
   logic        refused_d, clear_hit, good_msg, bad_msg, restart;
   logic [15:0] rdata_d;
   logic [31:0] bit_cyc, idle_target;
   logic        enabled;

   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0]  b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_step

   function automatic logic [31:0] rate_cycles(input logic [15:0] code);
      logic [31:0] r;
      r = 32'(CLK_HZ / RATE_TABLE[RATE_CODES - 1]);
      if (code < 16'(RATE_CODES)) begin
         r = 32'(CLK_HZ / RATE_TABLE[code[3:0]]);
      end
      return r;
   endfunction : rate_cycles

   assign enabled = (protocol_q == PROTO_MODBUS);
   assign bit_cyc = rate_cycles(rate_q);
   assign idle_target = 32'((bit_cyc * BITS_PER_CHAR * IDLE_HALF_CHARS + 1)
                            / 2);

   // Access decode: out-of-range values are refused rather than clipped
   always_comb begin
      refused_d = 1'b0;
      rdata_d   = 16'h0000;
      unique case (preq.addr)
         ADDR_SETPOINT_SRC: begin
            rdata_d   = setpoint_q;
            refused_d = preq.wr && (preq.wdata > MAX_SETPOINT);
         end
         ADDR_COMMAND_SRC: begin
            rdata_d   = command_q;
            refused_d = preq.wr && ((preq.wdata < MIN_COMMAND) ||
                                    (preq.wdata > MAX_COMMAND));
         end
         ADDR_MSG_COUNTERS: begin
            rdata_d   = 16'(bad_q * XX_WEIGHT) + 16'(good_q);
            refused_d = preq.wr;
         end
         ADDR_PROTOCOL: begin
            rdata_d   = protocol_q;
            refused_d = preq.wr && (preq.wdata > MAX_PROTOCOL);
         end
         ADDR_STATION: begin
            rdata_d   = station_q;
            refused_d = preq.wr && ((preq.wdata == 16'h0000) ||
                                    (preq.wdata > MAX_STATION));
         end
         ADDR_RATE_CODE: begin
            rdata_d   = rate_q;
            refused_d = preq.wr && (preq.wdata > MAX_RATE_CODE);
         end
         ADDR_PARITY: begin
            rdata_d   = parity_q;
            refused_d = preq.wr && (preq.wdata > MAX_PARITY);
         end
         ADDR_TIMEOUT: begin
            rdata_d   = timeout_q;
            refused_d = preq.wr && (preq.wdata > MAX_TIMEOUT);
         end
         ADDR_CNT_CLEAR: begin
            rdata_d   = clear_q;
            refused_d = preq.wr && (preq.wdata > MAX_CNT_CLEAR);
         end
         default: begin
            refused_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prsp <= '0;
      end else begin
         prsp.valid   <= preq.rd | preq.wr;
         prsp.refused <= (preq.rd | preq.wr) & refused_d;
         prsp.rdata   <= preq.rd ? rdata_d : 16'h0000;
      end
   end

   // only read-write parameters take accepted writes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         setpoint_q <= RST_SETPOINT_SRC;
         command_q  <= RST_COMMAND_SRC;
         protocol_q <= RST_PROTOCOL;
         station_q  <= RST_STATION;
         rate_q     <= RST_RATE_CODE;
         parity_q   <= RST_PARITY;
         timeout_q  <= RST_TIMEOUT;
         clear_q    <= RST_CNT_CLEAR;
      end else if (preq.wr && !refused_d) begin
         unique case (preq.addr)
            ADDR_SETPOINT_SRC: setpoint_q <= preq.wdata;
            ADDR_COMMAND_SRC:  command_q  <= preq.wdata;
            ADDR_PROTOCOL:     protocol_q <= preq.wdata;
            ADDR_STATION:      station_q  <= preq.wdata;
            ADDR_RATE_CODE:    rate_q     <= preq.wdata;
            ADDR_PARITY:       parity_q   <= preq.wdata;
            ADDR_TIMEOUT:      timeout_q  <= preq.wdata;
            ADDR_CNT_CLEAR:    clear_q    <= preq.wdata;
            default:           clear_q    <= clear_q;
         endcase
      end
   end

   // running frame check, residue zero when check field matches
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         crc_q    <= CRC_INIT;
         nbytes_q <= 8'h00;
         faddr_q  <= 8'h00;
      end else if (frame_start) begin
         crc_q    <= rx_byte_valid ? crc_step(CRC_INIT, rx_byte) : CRC_INIT;
         nbytes_q <= rx_byte_valid ? 8'h01 : 8'h00;
         faddr_q  <= rx_byte_valid ? rx_byte : 8'h00;
      end else if (rx_byte_valid) begin
         crc_q <= crc_step(crc_q, rx_byte);
         if (nbytes_q == 8'h00) begin
            faddr_q <= rx_byte;
         end
         if (nbytes_q != 8'hFF) begin
            nbytes_q <= nbytes_q + 8'h01;
         end
      end
   end

   assign good_msg = enabled && frame_end && (crc_q == CRC_RESIDUE) &&
                     (nbytes_q >= MIN_FRAME);
   assign bad_msg  = enabled && frame_end && !good_msg;

   // reply only on own address, broadcast executes silently
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         frame_evt <= '0;
      end else begin
         frame_evt.reply_en  <= good_msg && (faddr_q == station_q[7:0]);
         // address zero is treated as broadcast
         frame_evt.exec_en   <= good_msg && ((faddr_q == station_q[7:0]) ||
                                             (faddr_q == BROADCAST_ADDR));
         frame_evt.crc_error <= bad_msg;
      end
   end

   // clear on accepted write of 1; a same-cycle event still counts
   assign clear_hit = preq.wr && !refused_d && (preq.addr == ADDR_CNT_CLEAR)
                      && (preq.wdata == CLEAR_COUNTERS);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bad_q  <= 7'h00;
         good_q <= 10'h000;
      end else begin
         if (clear_hit) begin
            bad_q  <= bad_msg ? 7'h01 : 7'h00;
            good_q <= good_msg ? 10'h001 : 10'h000;
         end else begin
            if (bad_msg && bad_q != BAD_MAX) begin
               bad_q <= bad_q + 7'h01;
            end
            if (good_msg && good_q != GOOD_MAX) begin
               good_q <= good_q + 10'h001;
            end
         end
      end
   end

   // idle time since the last received byte
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         idle_cnt_q    <= 32'h0000_0000;
         turnaround_ok <= 1'b0;
      end else begin
         if (rx_byte_valid) begin
            idle_cnt_q <= 32'h0000_0000;
         end else if (idle_cnt_q < idle_target) begin
            idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
         end
         turnaround_ok <= !rx_byte_valid && (idle_cnt_q >= idle_target);
      end
   end

   // restart on valid message or a change of timeout or enable
   assign restart = good_msg ||
      (preq.wr && !refused_d && (preq.addr == ADDR_TIMEOUT) &&
       (preq.wdata != timeout_q)) ||
      (preq.wr && !refused_d && (preq.addr == ADDR_PROTOCOL) &&
       (preq.wdata != protocol_q));

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sec_pre_q      <= 32'h0000_0000;
         sec_cnt_q      <= 8'h00;
         fieldbus_error <= 1'b0;
         error_code     <= 8'h00;
      end else if (restart || !enabled || timeout_q == 16'h0000) begin
         sec_pre_q      <= 32'h0000_0000;
         sec_cnt_q      <= 8'h00;
         fieldbus_error <= 1'b0;
         error_code     <= 8'h00;
      end else if (sec_cnt_q >= timeout_q[7:0]) begin
         fieldbus_error <= 1'b1;
         error_code     <= FIELDBUS_ERR;
      end else if (sec_pre_q == 32'(CLK_HZ - 1)) begin
         sec_pre_q <= 32'h0000_0000;
         sec_cnt_q <= sec_cnt_q + 8'h01;
      end else begin
         sec_pre_q <= sec_pre_q + 32'h0000_0001;
      end
   end

   // line settings handed to the serial engine
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         link_cfg <= '0;
      end else begin
         // enable only for the Modbus code
         link_cfg.enable      <= enabled;
         link_cfg.bit_cycles  <= bit_cyc;
         link_cfg.parity_mode <= parity_q[1:0];
         link_cfg.two_stop    <= (parity_q == PARITY_NONE);
      end
   end

   // Source selection
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_from_terminals  <= 1'b0;
         cmd_from_panel      <= 1'b0;
         cmd_from_bus        <= 1'b0;
         setpoint_from_bus   <= 1'b0;
         active_setpoint_src <= SP_FIXED_ZERO;
      end else begin
         cmd_from_terminals <= (command_q == CMD_TERMINALS);
         cmd_from_panel     <= (command_q == CMD_PANEL);
         cmd_from_bus       <= (command_q == CMD_BUS);
         // fixed frequencies win over every source
         setpoint_from_bus   <= !fixed_freq_active &&
                                (setpoint_q[2:0] == SP_BUS);
         active_setpoint_src <= fixed_freq_active ? SP_FIXED_ZERO
                                                  : setpoint_q[2:0];
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   station_legal_a: assert property (
      station_q != 16'h0000 && station_q <= MAX_STATION)
      else $error("station address out of range");
   protocol_gate_a: assert property (
      protocol_q != PROTO_MODBUS |=> !link_cfg.enable)
      else $error("link enabled while protocol off");
   stop_bits_a: assert property (
      parity_q == PARITY_NONE |=> link_cfg.two_stop)
      else $error("no parity without two stop bits");
   counter_limit_a: assert property (
      bad_q <= BAD_MAX && good_q <= GOOD_MAX)
      else $error("message counter beyond limit");
   status_ro_a: assert property (
      preq.wr && preq.addr == ADDR_MSG_COUNTERS |=> prsp.valid && prsp.refused)
      else $error("write to status not refused");
   clear_zero_a: assert property (
      clear_hit && !good_msg && !bad_msg |=> bad_q == 7'h00 && good_q == 10'h000)
      else $error("counters not cleared");
   timeout_cause_a: assert property (
      $rose(fieldbus_error) |-> $past(enabled) && $past(timeout_q) != 16'h0000
      && error_code == FIELDBUS_ERR)
      else $error("fieldbus error without armed timeout");
   bus_cmd_a: assert property (
      ##1 cmd_from_bus == $past(command_q == CMD_BUS))
      else $error("command source decode wrong");
   fixed_prio_a: assert property (
      fixed_freq_active |=> active_setpoint_src == SP_FIXED_ZERO
      && !setpoint_from_bus)
      else $error("fixed frequency lost priority");
   reply_addr_a: assert property (
      frame_evt.reply_en |-> $past(faddr_q) == $past(station_q[7:0])
      && frame_evt.exec_en)
      else $error("reply to foreign address");
   crc_flag_a: assert property (
      enabled && frame_end && crc_q != CRC_RESIDUE |=> frame_evt.crc_error
      && !frame_evt.exec_en)
      else $error("frame check mismatch not flagged");
   idle_gap_a: assert property (
      rx_byte_valid |=> !turnaround_ok ##1 !turnaround_ok)
      else $error("turnaround allowed too early");
   silence_restart_a: assert property (
      good_msg |=> !fieldbus_error && sec_cnt_q == 8'h00)
      else $error("silence timer not restarted");
   good_sat_a: assert property (
      good_q == GOOD_MAX && !clear_hit |=> good_q == GOOD_MAX)
      else $error("good counter wrapped");

   reply_seen_c:     cover property (frame_evt.reply_en);
   broadcast_seen_c: cover property (frame_evt.exec_en && !frame_evt.reply_en);
   crc_error_c:      cover property (frame_evt.crc_error);
   timeout_hit_c:    cover property ($rose(fieldbus_error));

endmodule : modbus_slave_link_config

//--- modbus_link_pkg.sv
// Shared constants and carrier types for the fieldbus link configuration.
// Assumes a single 100 MHz core clock and a frame engine on the same clock.
package modbus_link_pkg;

   // Parameter identifiers as seen over the bus
   localparam logic [15:0] ADDR_SETPOINT_SRC = 16'h0075;
   localparam logic [15:0] ADDR_COMMAND_SRC  = 16'h007D;
   localparam logic [15:0] ADDR_MSG_COUNTERS = 16'h0328;
   localparam logic [15:0] ADDR_PROTOCOL     = 16'h0329;
   localparam logic [15:0] ADDR_STATION      = 16'h032A;
   localparam logic [15:0] ADDR_RATE_CODE    = 16'h032B;
   localparam logic [15:0] ADDR_PARITY       = 16'h032D;
   localparam logic [15:0] ADDR_TIMEOUT      = 16'h032E;
   localparam logic [15:0] ADDR_CNT_CLEAR    = 16'h032F;

   // Reset values
   localparam logic [15:0] RST_SETPOINT_SRC = 16'h0003;
   localparam logic [15:0] RST_COMMAND_SRC  = 16'h0001;
   localparam logic [15:0] RST_PROTOCOL     = 16'h0000;
   localparam logic [15:0] RST_STATION      = 16'h0001;
   localparam logic [15:0] RST_RATE_CODE    = 16'h0005;
   localparam logic [15:0] RST_PARITY       = 16'h0000;
   localparam logic [15:0] RST_TIMEOUT      = 16'h0000;
   localparam logic [15:0] RST_CNT_CLEAR    = 16'h0000;

   // Legal value limits
   localparam logic [15:0] MAX_PROTOCOL  = 16'h0001;
   localparam logic [15:0] MAX_STATION   = 16'h00FF;
   localparam logic [15:0] MAX_RATE_CODE = 16'h0008;
   localparam logic [15:0] MAX_PARITY    = 16'h0002;
   localparam logic [15:0] MAX_TIMEOUT   = 16'h00FF;
   localparam logic [15:0] MAX_CNT_CLEAR = 16'h0001;
   localparam logic [15:0] MIN_COMMAND   = 16'h0001;
   localparam logic [15:0] MAX_COMMAND   = 16'h0003;
   localparam logic [15:0] MAX_SETPOINT  = 16'h0004;

   // Codes
   localparam logic [15:0] PROTO_MODBUS   = 16'h0001;
   localparam logic [15:0] PARITY_NONE    = 16'h0000;
   localparam logic [15:0] CLEAR_COUNTERS = 16'h0001;
   localparam logic [15:0] CMD_TERMINALS  = 16'h0001;
   localparam logic [15:0] CMD_PANEL      = 16'h0002;
   localparam logic [15:0] CMD_BUS        = 16'h0003;
   localparam logic [2:0]  SP_FIXED_ZERO  = 3'h0;
   localparam logic [2:0]  SP_BUS         = 3'h2;
   localparam logic [7:0]  BROADCAST_ADDR = 8'h00;
   localparam logic [7:0]  FIELDBUS_ERR   = 8'h35;

   // Counter limits and status packing (xx.yyy as xx*1000+yyy)
   localparam logic [6:0]  BAD_MAX   = 7'h40;
   localparam logic [9:0]  GOOD_MAX  = 10'h3E7;
   localparam int unsigned XX_WEIGHT = 1000;

   // Character framing: start + 8 data + parity/stop = 11 bits either way
   localparam int unsigned BITS_PER_CHAR   = 11;
   localparam int unsigned IDLE_HALF_CHARS = 7;
   localparam int unsigned RATE_CODES      = 9;
   localparam int unsigned RATE_TABLE [RATE_CODES] =
      '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600};

   // Frame check
   localparam logic [15:0] CRC_INIT    = 16'hFFFF;
   localparam logic [15:0] CRC_POLY    = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;
   localparam logic [7:0]  MIN_FRAME   = 8'h04;

   localparam int unsigned CLK_HZ_DEFAULT = 100_000_000;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } param_req_t;

   typedef struct packed {
      logic        valid;
      logic        refused;
      logic [15:0] rdata;
   } param_rsp_t;

   typedef struct packed {
      logic        enable;
      logic [31:0] bit_cycles;
      logic [1:0]  parity_mode;
      logic        two_stop;
   } link_cfg_t;

   typedef struct packed {
      logic exec_en;
      logic reply_en;
      logic crc_error;
   } frame_evt_t;

endpackage : modbus_link_pkg

//--- modbus_master_model.sv
// Behavioural bus master driving the received-byte stream of the slave.
// Assumes the slave samples the stream on core_clk rising edges.
module modbus_master_model (
   // Clock
   input  wire logic core_clk,
   // Received byte stream
   output logic      rx_byte_valid,
   output logic [7:0] rx_byte,
   output logic      frame_start,
   output logic      frame_end
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_byte_valid = 1'b0;
      rx_byte       = 8'hA5;
      frame_start   = 1'b0;
      frame_end     = 1'b0;
   end
   task automatic send_frame(input logic [7:0] st, input bit bad);
      logic [7:0]  f [6];
      logic [15:0] crc;
      repeat (100) @(posedge core_clk);
      f = '{st, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
      crc = 16'hFFFF;
      for (int i = 0; i < 4; i++) begin
         crc = crc ^ {8'h00, f[i]};
         for (int b = 0; b < 8; b++)
            crc = crc[0] ? ((crc >> 1) ^ 16'hA001) : (crc >> 1);
      end
      f[4] = crc[7:0] ^ {7'h00, bad};
      f[5] = crc[15:8];
      for (int i = 0; i < 6; i++) begin
         @(posedge core_clk);
         #1;
         frame_start   = (i == 0);
         rx_byte_valid = 1'b1;
         rx_byte       = f[i];
      end
      @(posedge core_clk);
      #1;
      frame_start   = 1'b0;
      rx_byte_valid = 1'b0;
      rx_byte       = ~rx_byte;
      frame_end     = 1'b1;
      @(posedge core_clk);
      #1;
      frame_end = 1'b0;
   endtask : send_frame
endmodule : modbus_master_model

//--- modbus_slave_link_config_test.sv
// Self-checking bench for the slave link configuration block.
// Assumes the parameter port contract and the byte-level master model.
module modbus_slave_link_config_test;
   import modbus_link_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // Short second so the silence timeout fits the run
   localparam int unsigned HZ = 20000;
   localparam logic [15:0] REGS [9] = '{ADDR_SETPOINT_SRC, ADDR_COMMAND_SRC,
      ADDR_MSG_COUNTERS, ADDR_PROTOCOL, ADDR_STATION, ADDR_RATE_CODE,
      ADDR_PARITY, ADDR_TIMEOUT, ADDR_CNT_CLEAR};
   localparam logic [15:0] RSTV [9] = '{16'h3, 16'h1, 16'h0, 16'h0, 16'h1,
      16'h5, 16'h0, 16'h0, 16'h0};
   logic       core_clk;
   logic       nrst;
   param_req_t preq;
   param_rsp_t prsp;
   logic       rx_byte_valid;
   logic [7:0] rx_byte;
   logic       frame_start;
   logic       frame_end;
   logic       fixed_freq_active;
   link_cfg_t  link_cfg;
   frame_evt_t frame_evt;
   logic       fieldbus_error;
   logic       turnaround_ok;
   logic [7:0] error_code;
   logic [2:0] cmd;
   logic       sp_bus;
   logic [2:0] sp_src;
   int         fail_count;
   int         compares;

   modbus_slave_link_config #(.CLK_HZ(HZ)) dut_u (.core_clk(core_clk),
      .nrst(nrst), .preq(preq), .prsp(prsp), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .frame_start(frame_start), .frame_end(frame_end),
      .fixed_freq_active(fixed_freq_active), .link_cfg(link_cfg),
      .frame_evt(frame_evt), .turnaround_ok(turnaround_ok),
      .fieldbus_error(fieldbus_error),
      .error_code(error_code), .cmd_from_terminals(cmd[2]),
      .cmd_from_panel(cmd[1]), .cmd_from_bus(cmd[0]),
      .setpoint_from_bus(sp_bus), .active_setpoint_src(sp_src));
   modbus_master_model master_u (.core_clk(core_clk),
      .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
      .frame_start(frame_start), .frame_end(frame_end));

   task automatic chk(input string what, input logic [39:0] exp, got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // One access, answer checked, then one cycle for settings to land
   task automatic acc(input logic w, input logic [15:0] a, d,
                      input logic refd, input logic [15:0] exp);
      @(posedge core_clk);
      #1;
      preq = '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge core_clk);
      #1;
      preq = '0;
      chk("valid", 1, prsp.valid);
      chk("refused", refd, prsp.refused);
      if (!w && !refd)
         chk("rdata", exp, prsp.rdata);
      @(posedge core_clk);
      #1;
   endtask : acc
   task automatic frame(input logic [7:0] st, input bit bad, logic [2:0] ev);
      master_u.send_frame(st, bad);
      chk("frame_evt", ev, frame_evt);
      // Last byte went by two cycles ago, far short of 3.5 characters
      chk("turn_early", 0, turnaround_ok);
      repeat (80) @(posedge core_clk);
      chk("turn", 1, turnaround_ok);
   endtask : frame
   task automatic close_out();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      fail_count++;
      close_out();
   end
   initial begin
      nrst = 1'b0;
      preq = '0;
      fixed_freq_active = 1'b0;
      fail_count = 0;
      compares = 0;
      repeat (16) @(posedge core_clk);
      #1;
      nrst = 1'b1;
      foreach (REGS[i]) acc(0, REGS[i], 0, 0, RSTV[i]);
      chk("cfg", {1'b0, HZ / 9600, 2'h0, 1'b1}, link_cfg);
      chk("src", 6'b100011, {cmd, sp_src});
      $display("test reset_values done");
      acc(1, ADDR_MSG_COUNTERS, 16'h0005, 1, 0);
      acc(0, 16'h0100, 0, 1, 0);
      acc(1, ADDR_STATION, 16'h0000, 1, 0);
      acc(1, ADDR_STATION, 16'h00FF, 0, 0);
      acc(0, ADDR_STATION, 0, 0, 16'h00FF);
      acc(1, ADDR_PARITY, 16'h0003, 1, 0);
      $display("test access_rights done");
      for (int i = 0; i < 9; i++) begin
         acc(1, ADDR_RATE_CODE, 16'(i), 0, 0);
         chk("bit_cycles", HZ / RATE_TABLE[i], link_cfg.bit_cycles);
      end
      for (int i = 0; i < 3; i++) begin
         acc(1, ADDR_PARITY, 16'(i), 0, 0);
         chk("framing", {i[1:0], i == 0}, link_cfg[2:0]);
      end
      acc(1, ADDR_RATE_CODE, 16'h0005, 0, 0);
      $display("test line_settings done");
      for (int i = 1; i < 4; i++) begin
         acc(1, ADDR_COMMAND_SRC, 16'(i), 0, 0);
         chk("cmd", 3'b100 >> (i - 1), cmd);
      end
      acc(1, ADDR_SETPOINT_SRC, 16'h0002, 0, 0);
      chk("sp", 4'hA, {sp_bus, sp_src});
      fixed_freq_active = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk("sp_fixed", 4'h0, {sp_bus, sp_src});
      fixed_freq_active = 1'b0;
      $display("test sources done");
      frame(8'hFF, 0, 3'b000);
      acc(1, ADDR_PROTOCOL, 16'h0001, 0, 0);
      chk("enable", 1, link_cfg.enable);
      acc(1, ADDR_STATION, 16'h0005, 0, 0);
      frame(8'h05, 0, 3'b110);
      frame(8'h00, 0, 3'b100);
      frame(8'h07, 0, 3'b000);
      frame(8'h05, 1, 3'b001);
      acc(0, ADDR_MSG_COUNTERS, 0, 0, 16'd1003);
      acc(1, ADDR_CNT_CLEAR, 16'h0001, 0, 0);
      acc(0, ADDR_MSG_COUNTERS, 0, 0, 16'h0000);
      acc(1, ADDR_CNT_CLEAR, 16'h0000, 0, 0);
      $display("test frames done");
      acc(1, ADDR_TIMEOUT, 16'h0001, 0, 0);
      repeat (HZ - 20) @(posedge core_clk);
      chk("early", 0, fieldbus_error);
      repeat (40) @(posedge core_clk);
      chk("err", 9'h135, {fieldbus_error, error_code});
      acc(1, ADDR_TIMEOUT, 16'h0000, 0, 0);
      repeat (2) @(posedge core_clk);
      chk("err_off", 9'h000, {fieldbus_error, error_code});
      $display("test silence_timeout done");
      close_out();
   end
endmodule : modbus_slave_link_config_test
